/* core/afoc_frame.sv */
// serial conversion frame with offset self-calibration
// What this block and its host must do
// [R1] calibrate offset in any frame holding at least 32 sclk falling edges
// [R2] first 14 sclks convert the sample taken at select fall, shift out
// [R3] calibration starts on falling edge 17, finishes on edge 32
// [R4] data output held low from falling edge 14 to frame end
// [R5] data output released once select returns high
// [R6] frame shorter than 32 edges (16 for the power-up frame) leaves offset store untouched
// [R7] later results corrected by stored offset before shifting out
// [R8] host keeps sclk at or below 16 or 12 MHz during calibration
// [R9] host allows at least 15 sclk periods of calibration time
// [R10] frame runs select fall to select rise; sample taken at start
// [R11] leading zero at select fall, then zero and 12 bits msb first
// [R12] offset store cleared at power-up; first frame calibrates over 16 edges
// [R13] host keeps select high at least 200 ns between frames
// [R14] host counts edges, ending calibration frames after edge 32
`include "afoc_regs.svh"
`default_nettype none
module afoc_frame
    import afoc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic selectPin_b,
    input wire logic sclkPin,
    input wire logic [`AFOC_RES_W-1:0] sampleCode,
    input wire logic [`AFOC_RES_W-1:0] offsetMeas,
    output logic sdoOut,
    output logic sdoOe,
    output logic calBusy,
    output logic [`AFOC_RES_W-1:0] offsetValue
);
    localparam int SYNC_W = 2 + 2 * `AFOC_RES_W;

    logic [1:0] rstPipe_q;
    logic rstSync_b;
    logic [SYNC_W-1:0] syncOut;
    logic selSync;
    logic sclkSync;
    logic [`AFOC_RES_W-1:0] sampleSync;
    logic [`AFOC_RES_W-1:0] measSync;
    logic selPrev_q;
    logic sclkPrev_q;
    logic selFall;
    logic selRise;
    logic sclkFall;
    afoc_state_t state_q, state_d;
    afoc_frame_t frame_q, frame_d;
    logic [`AFOC_SHIFT_W-1:0] shift_q, shift_d;
    logic [`AFOC_RES_W-1:0] ofs_q, ofs_d;
    logic [`AFOC_RES_W-1:0] calPend_q, calPend_d;
    logic [`AFOC_RES_W-1:0] corrRes;
    logic sdo_d;
    logic oe_d;
    logic commit;
    logic [`AFOC_CNT_W-1:0] nextCnt;

    // reset is asserted at once but released in step with the clock
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSync_b = rstPipe_q[1];

    afoc_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rstSync_b),
        .asyncIn({selectPin_b, sclkPin, sampleCode, offsetMeas}),
        .syncOut(syncOut)
    );
    assign {selSync, sclkSync, sampleSync, measSync} = syncOut;

    // history resets to the synchroniser's reset value: a high history over
    // a low synced copy would fake a select fall and eat the power-up frame;
    // the rise seen once the pin syncs in is ignored while idle
    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            selPrev_q <= 1'b0;
            sclkPrev_q <= 1'b0;
        end else begin
            selPrev_q <= selSync;
            sclkPrev_q <= sclkSync;
        end
    end

    // [R10] frame edges
    assign selFall = selPrev_q & ~selSync;
    assign selRise = ~selPrev_q & selSync;
    assign sclkFall = sclkPrev_q & ~sclkSync & ~selSync;

    // [R7] offset correction
    // floors at zero: a code below the offset cannot go negative
    assign corrRes = (sampleSync > ofs_q) ? (sampleSync - ofs_q)
                                          : `AFOC_RES_W'(0);

    assign nextCnt = (frame_q.edgeCnt == `AFOC_CNT_MAX) ? frame_q.edgeCnt
                   : `AFOC_CNT_W'(frame_q.edgeCnt + 1'b1);

    // [R1] commit point
    assign commit = sclkFall && (state_q != ST_IDLE) && frame_q.calBusy &&
                    (nextCnt == (frame_q.powerUp ? `AFOC_PWR_CAL_EDGES
                                                 : `AFOC_CAL_EDGES));

    always_comb begin
        state_d = state_q;
        frame_d = frame_q;
        shift_d = shift_q;
        ofs_d = ofs_q;
        calPend_d = calPend_q;
        sdo_d = sdoOut;
        oe_d = sdoOe;
        if (selFall) begin
            state_d = ST_SHIFT;
            frame_d.edgeCnt = '0;
            frame_d.calBusy = frame_q.powerUp;
            // [R11] leading zero
            oe_d = 1'b1;
            sdo_d = 1'b0;
            // [R2] sample held
            shift_d = frame_q.powerUp ? '0 : {1'b0, corrRes};
            // [R12] power-up cal
            if (frame_q.powerUp) begin
                calPend_d = measSync;
            end
        end else if (selRise && state_q != ST_IDLE) begin
            state_d = ST_IDLE;
            // [R5] release output
            oe_d = 1'b0;
            sdo_d = 1'b0;
            // [R6] abandon cal
            frame_d.calBusy = 1'b0;
            frame_d.powerUp = 1'b0;
        end else if (sclkFall && state_q != ST_IDLE) begin
            frame_d.edgeCnt = nextCnt;
            // [R11] msb first
            sdo_d = shift_q[`AFOC_SHIFT_W-1];
            shift_d = {shift_q[`AFOC_SHIFT_W-2:0], 1'b0};
            // [R4] hold low
            if (nextCnt >= `AFOC_DATA_EDGES) begin
                state_d = ST_TAIL;
                sdo_d = 1'b0;
            end
            // [R3] start cal
            if (!frame_q.powerUp && nextCnt == `AFOC_CAL_START) begin
                frame_d.calBusy = 1'b1;
                calPend_d = measSync;
            end
            // [R1] store result
            if (commit) begin
                ofs_d = calPend_q;
                frame_d.calBusy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state_q <= ST_IDLE;
            frame_q <= '{powerUp: 1'b1, calBusy: 1'b0, edgeCnt: '0};
            shift_q <= '0;
            // [R12] cleared store
            ofs_q <= `AFOC_OFS_RESET;
            calPend_q <= `AFOC_OFS_RESET;
            sdoOut <= 1'b0;
            sdoOe <= 1'b0;
        end else begin
            state_q <= state_d;
            frame_q <= frame_d;
            shift_q <= shift_d;
            ofs_q <= ofs_d;
            calPend_q <= calPend_d;
            sdoOut <= sdo_d;
            sdoOe <= oe_d;
        end
    end

    assign calBusy = frame_q.calBusy;
    assign offsetValue = ofs_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstSync_b);

    property p_cal_commit;
        sclkFall && state_q != ST_IDLE && !frame_q.powerUp &&
        frame_q.calBusy && frame_q.edgeCnt == 6'h1f
        |=> ofs_q == $past(calPend_q) && !calBusy;
    endproperty
    a_cal_commit: assert property (p_cal_commit) // [R1]
        else $error("offset store not loaded at edge 32");

    property p_cal_start;
        sclkFall && state_q != ST_IDLE && !frame_q.powerUp &&
        frame_q.edgeCnt == 6'h10
        |=> calBusy && calPend_q == $past(measSync);
    endproperty
    a_cal_start: assert property (p_cal_start) // [R3]
        else $error("calibration did not start at edge 17");

    property p_tail_low;
        state_q == ST_TAIL |-> !sdoOut && sdoOe;
    endproperty
    a_tail_low: assert property (p_tail_low) // [R4]
        else $error("data output not low after edge 14");

    property p_release;
        selRise && state_q != ST_IDLE |=> !sdoOe ##1 !sdoOe;
    endproperty
    a_release: assert property (p_release) // [R5]
        else $error("data output not released after select rise");

    property p_ofs_hold;
        !commit |=> $stable(ofs_q);
    endproperty
    a_ofs_hold: assert property (p_ofs_hold) // [R6]
        else $error("offset store changed without a full calibration");

    property p_corrected;
        selFall && !frame_q.powerUp
        |=> !shift_q[`AFOC_SHIFT_W-1] &&
            (($past(sampleSync) > $past(ofs_q))
                ? (shift_q[`AFOC_RES_W-1:0] + $past(ofs_q) ==
                   $past(sampleSync))
                : (shift_q[`AFOC_RES_W-1:0] == `AFOC_RES_W'(0)));
    endproperty
    a_corrected: assert property (p_corrected) // [R7]
        else $error("loaded result not offset corrected");

    property p_lead_zero;
        selFall |=> sdoOe && !sdoOut && frame_q.edgeCnt == 6'h00;
    endproperty
    a_lead_zero: assert property (p_lead_zero) // [R11]
        else $error("no leading zero at select fall");

    property p_power_low;
        frame_q.powerUp && state_q != ST_IDLE |-> !sdoOut;
    endproperty
    a_power_low: assert property (p_power_low) // [R12]
        else $error("data output not low in power-up frame");

    property p_idle_off;
        state_q == ST_IDLE |-> !sdoOe;
    endproperty
    a_idle_off: assert property (p_idle_off) // [R10]
        else $error("data output driven outside a frame");

    c_normal_cal: cover property (commit && !frame_q.powerUp);
    c_power_cal: cover property (commit && frame_q.powerUp);
    c_short_cal: cover property (selRise && calBusy);
endmodule // afoc_frame
`default_nettype wire

/* core/afoc_regs.svh */
// constants for the offset-calibrating conversion frame
`ifndef AFOC_REGS_SVH
`define AFOC_REGS_SVH

`define AFOC_RES_W 12
`define AFOC_SHIFT_W 13
`define AFOC_CNT_W 6
`define AFOC_CNT_MAX 6'h3f
`define AFOC_DATA_EDGES 6'h0e
`define AFOC_CAL_START 6'h11
`define AFOC_CAL_EDGES 6'h20
`define AFOC_PWR_CAL_EDGES 6'h10
`define AFOC_OFS_RESET 12'h000
`define AFOC_CLK_NS 100
`define AFOC_ACQ_NS 200
`define AFOC_ACQ_CYC ((`AFOC_ACQ_NS + `AFOC_CLK_NS - 1) / `AFOC_CLK_NS)

`endif

/* core/afoc_pkg.sv */
// types shared by the conversion frame logic
`default_nettype none
package afoc_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_TAIL
    } afoc_state_t;

    typedef struct packed {
        logic powerUp;
        logic calBusy;
        logic [5:0] edgeCnt;
    } afoc_frame_t;
endpackage : afoc_pkg
`default_nettype wire

/* core/afoc_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
`default_nettype none
module afoc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // afoc_sync
`default_nettype wire

/* testbench/afoc_host.sv */
// host model: drives select and serial clock, reads the data line
`default_nettype none
module afoc_host (
    input wire logic clk_sys,
    input wire logic sdoLine,
    input wire logic sdoOe,
    input wire logic calBusy,
    output logic selectPin_b,
    output logic sclkPin
);
    timeunit 1ns;
    timeprecision 1ns;
    // clock stands still high outside frames
    initial begin
        selectPin_b = 1'b1;
        sclkPin = 1'b1;
    end
    // 800 ns clock, n falling edges per frame
    task automatic frame(input int n, output logic [31:0] bits,
        output logic [31:0] busy, output logic oe);
        bits = '0;
        busy = '0;
        @(posedge clk_sys) selectPin_b <= 1'b0;
        repeat (6) @(posedge clk_sys);
        bits[0] = sdoLine;
        busy[0] = calBusy;
        oe = sdoOe;
        repeat (2) @(posedge clk_sys);
        for (int k = 1; k <= n; k++) begin
            sclkPin <= 1'b0;
            repeat (4) @(posedge clk_sys);
            sclkPin <= 1'b1;
            repeat (2) @(posedge clk_sys);
            // sampled three cycles after the answer lands
            if (k < 32) begin
                bits[k] = sdoLine;
                busy[k] = calBusy;
            end
            oe = oe & sdoOe;
            repeat (2) @(posedge clk_sys);
        end
        selectPin_b <= 1'b1;
        // select high well over 200 ns
        repeat (8) @(posedge clk_sys);
    endtask
endmodule // afoc_host
`default_nettype wire

/* testbench/tb_adc_frame_offset_calibration.sv */
// bench: frames of many lengths compared with an integer model
`default_nettype none
module tb_adc_frame_offset_calibration;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_b, selectPin_b, sclkPin, sdoOut, sdoOe, calBusy;
    logic [11:0] sampleCode, offsetMeas, offsetValue;
    logic sdoLine;
    int n_mismatch, n_checks, ofs, pu;
    int lens[10] = '{20, 14, 31, 32, 17, 40, 16, 10, 14, 32};
    // released line shows the inverse of the last bit, never a stale copy
    assign sdoLine = sdoOe ? sdoOut : ~sdoOut;
    afoc_frame afoc_frame_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .selectPin_b(selectPin_b), .sclkPin(sclkPin),
        .sampleCode(sampleCode), .offsetMeas(offsetMeas),
        .sdoOut(sdoOut), .sdoOe(sdoOe), .calBusy(calBusy),
        .offsetValue(offsetValue));
    afoc_host afoc_host_inst (.clk_sys(clk_sys), .sdoLine(sdoLine),
        .sdoOe(sdoOe), .calBusy(calBusy), .selectPin_b(selectPin_b),
        .sclkPin(sclkPin));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic fail(input string what);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, what);
    endtask
    task automatic check_frame(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) fail($sformatf("frame got %h want %h", got, exp));
    endtask
    task automatic check_ofs(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) fail($sformatf("offset got %h want %h", got, exp));
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk_sys) rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check_ofs(offsetValue, 12'h000);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        pu = 1;
        ofs = 0;
    endtask
    task automatic run_frame(input int n);
        logic [31:0] bits, busy, eb, ebusy;
        logic oe;
        int res;
        @(posedge clk_sys);
        sampleCode <= 12'($urandom);
        offsetMeas <= {2'h0, 10'($urandom)};
        repeat (4) @(posedge clk_sys);
        // corrected result floors at zero
        res = int'(sampleCode) - ofs;
        if (res < 0) res = 0;
        eb = '0;
        ebusy = '0;
        for (int k = 0; k < 32; k++) begin
            if (pu == 0 && k >= 2 && k <= 13) eb[k] = res[13-k];
            ebusy[k] = (k <= n) && (pu != 0 ? k < 16 : k >= 17);
        end
        afoc_host_inst.frame(n, bits, busy, oe);
        check_frame(bits, eb);
        check_frame(busy, ebusy);
        check_frame({31'h0, oe}, 32'h1);
        check_frame({31'h0, sdoOe}, 32'h0);
        if (pu != 0 ? n >= 16 : n >= 32) ofs = int'(offsetMeas);
        pu = 0;
        check_ofs(offsetValue, 12'(ofs));
        $display("frame of %0d edges done", n);
    endtask
    initial begin
        rst_b = 1'b0;
        sampleCode = '0;
        offsetMeas = '0;
        n_mismatch = 0;
        n_checks = 0;
        void'($urandom(32'h74a051a7));
        do_reset();
        foreach (lens[i]) begin
            // second reset: short power-up frame must not commit
            if (i == 7) do_reset();
            run_frame(lens[i]);
        end
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail("watchdog expired");
        stop_test();
    end
endmodule // tb_adc_frame_offset_calibration
`default_nettype wire
